// ===== sbsc_consts.svh
// constants for the burst sram cycle control block
`ifndef SBSC_CONSTS_SVH
`define SBSC_CONSTS_SVH
`define SBSC_BURST_BITS     2
`define SBSC_SLEEP_CYCLES   2'h2
`define SBSC_SLEEP_CNT_RST  2'h0
`define SBSC_COUNT_RST      2'h0
`define SBSC_BUF_DEPTH      2'h2
`define SBSC_BUF_CNT_RST    2'h0
`define SBSC_TRI_OFF        1'h1
`endif

// ===== sbsc_pkg.sv
// types for the burst sram cycle control block
package sbsc_pkg;
  typedef enum logic [1:0] {
    SBSC_BEAT_NONE,
    SBSC_BEAT_READ,
    SBSC_BEAT_WRITE
  } sbsc_beat_t;
  typedef enum logic [1:0] {
    SBSC_AWAKE,
    SBSC_ENTER,
    SBSC_ASLEEP,
    SBSC_EXIT
  } sbsc_sleep_t;
endpackage

// ===== sbsc_cycle_ctrl.sv
// cycle decode, burst counter, pipeline and array of a synchronous burst sram
`include "sbsc_consts.svh"
module sbsc_cycle_ctrl
  import sbsc_pkg::*;
#(
  parameter int ADDR_W = 21,
  parameter int LANES  = 4,
  parameter int BYTE_W = 8
)(
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic                      chip_select_1_n,
  input  wire logic                      chip_select_2,
  input  wire logic                      chip_select_3_n,
  input  wire logic                      burst_step_or_load,
  input  wire logic                      write_enable_n,
  input  wire logic [LANES-1:0]          byte_write_select_n,
  input  wire logic                      clock_qualifier,
  input  wire logic                      burst_order_select,
  input  wire logic                      output_enable_n,
  input  wire logic                      sleep_request,
  input  wire logic [ADDR_W-1:0]         address,
  input  wire logic [LANES*BYTE_W-1:0]   data_in,
  output logic      [LANES*BYTE_W-1:0]   data_out,
  output logic                           data_oe_n,
  input  wire logic [LANES-1:0]          parity_pins_in,
  output logic      [LANES-1:0]          parity_pins_out,
  output logic                           parity_pins_oe_n
);
  localparam int LANE_W = BYTE_W + 1;
  localparam int WORD_W = LANES * LANE_W;
  localparam int BB     = `SBSC_BURST_BITS;

  // ==========================================================
  // asynchronous pins
  // ==========================================================
  logic oe_n_meta_reg;
  logic oe_n_sync_reg;
  logic sleep_meta_reg;
  logic sleep_sync_reg;

  // output enable and sleep are not clock related, so both are synchronised
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      oe_n_meta_reg  <= 1'b1;
      oe_n_sync_reg  <= 1'b1;
      sleep_meta_reg <= 1'b0;
      sleep_sync_reg <= 1'b0;
    end
    else
    begin
      oe_n_meta_reg  <= output_enable_n;
      oe_n_sync_reg  <= oe_n_meta_reg;
      sleep_meta_reg <= sleep_request;
      sleep_sync_reg <= sleep_meta_reg;
    end
  end

  // ==========================================================
  // sleep control
  // ==========================================================
  sbsc_sleep_t sleep_state_reg;
  logic [1:0]  sleep_cnt_reg;
  logic        awake;

  assign awake = (sleep_state_reg == SBSC_AWAKE);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sleep_state_reg <= SBSC_AWAKE;
      sleep_cnt_reg   <= `SBSC_SLEEP_CNT_RST;
    end
    else
    begin
      unique case (sleep_state_reg)
        SBSC_AWAKE:
        begin
          sleep_cnt_reg <= `SBSC_SLEEP_CNT_RST;
          if (sleep_sync_reg)
            sleep_state_reg <= SBSC_ENTER;
        end
        SBSC_ENTER:
        begin
          sleep_cnt_reg <= sleep_cnt_reg + 2'h1;
          if (sleep_cnt_reg == `SBSC_SLEEP_CYCLES - 2'h1)
            sleep_state_reg <= SBSC_ASLEEP;
        end
        SBSC_ASLEEP:
        begin
          sleep_cnt_reg <= `SBSC_SLEEP_CNT_RST;
          if (!sleep_sync_reg)
            sleep_state_reg <= SBSC_EXIT;
        end
        SBSC_EXIT:
        begin
          sleep_cnt_reg <= sleep_cnt_reg + 2'h1;
          if (sleep_cnt_reg == `SBSC_SLEEP_CYCLES - 2'h1)
            sleep_state_reg <= SBSC_AWAKE;
        end
      endcase
    end
  end

  // ==========================================================
  // cycle decode
  // ==========================================================
  logic           selected;
  logic           any_lane;
  logic           adv;
  logic           buf_in_ready;
  sbsc_beat_t     beat;
  logic           burst_active_reg;
  logic           burst_write_reg;
  logic [ADDR_W-1:0] base_reg;
  logic [BB-1:0]  count_reg;
  logic [BB-1:0]  count_next;
  logic [BB-1:0]  step_low;
  logic [ADDR_W-1:0] beat_addr;

  assign selected = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign any_lane = !(&byte_write_select_n);
  // a stalled edge or a full buffer freezes every pipeline stage
  assign adv      = !clock_qualifier && awake && buf_in_ready;

  always_comb
  begin
    beat = SBSC_BEAT_NONE;
    if (!burst_step_or_load)
    begin
      if (selected && write_enable_n)
        beat = SBSC_BEAT_READ;
      else if (selected && any_lane)
        beat = SBSC_BEAT_WRITE;
    end
    else if (burst_active_reg)
    begin
      if (!burst_write_reg)
        beat = SBSC_BEAT_READ;
      else if (any_lane)
        beat = SBSC_BEAT_WRITE;
    end
  end

  assign count_next = count_reg + 2'h1;
  // linear adds the step, interleaved xors it into the start bits
  assign step_low   = burst_order_select ? (base_reg[BB-1:0] ^ count_next)
                                         : (base_reg[BB-1:0] + count_next);
  assign beat_addr  = burst_step_or_load ? {base_reg[ADDR_W-1:BB], step_low}
                                         : address;

  always_ff @(posedge core_clk)
  begin
    if (reset || !awake)
    begin
      burst_active_reg <= 1'b0;
      burst_write_reg  <= 1'b0;
      base_reg         <= '0;
      count_reg        <= `SBSC_COUNT_RST;
    end
    else if (adv)
    begin
      if (!burst_step_or_load)
      begin
        burst_active_reg <= selected;
        burst_write_reg  <= !write_enable_n;
        base_reg         <= address;
        count_reg        <= `SBSC_COUNT_RST;
      end
      else if (burst_active_reg)
        count_reg <= count_next;
    end
  end

  // ==========================================================
  // address and control pipeline
  // ==========================================================
  sbsc_beat_t        s1_beat_reg;
  sbsc_beat_t        s2_beat_reg;
  logic [ADDR_W-1:0] s1_addr_reg;
  logic [ADDR_W-1:0] s2_addr_reg;
  logic [LANES-1:0]  s1_lane_reg;
  logic [LANES-1:0]  s2_lane_reg;

  always_ff @(posedge core_clk)
  begin
    if (reset || !awake)
    begin
      // pending accesses are dropped on sleep entry
      s1_beat_reg <= SBSC_BEAT_NONE;
      s2_beat_reg <= SBSC_BEAT_NONE;
      s1_addr_reg <= '0;
      s2_addr_reg <= '0;
      s1_lane_reg <= '0;
      s2_lane_reg <= '0;
    end
    else if (adv)
    begin
      s1_beat_reg <= beat;
      s1_addr_reg <= beat_addr;
      s1_lane_reg <= ~byte_write_select_n;
      s2_beat_reg <= s1_beat_reg;
      s2_addr_reg <= s1_addr_reg;
      s2_lane_reg <= s1_lane_reg;
    end
  end

  // ==========================================================
  // storage array
  // ==========================================================
  logic [WORD_W-1:0] mem_reg [2**ADDR_W];
  logic [WORD_W-1:0] wr_word;
  logic [WORD_W-1:0] rd_word;
  logic              s2_write;

  assign s2_write = (s2_beat_reg == SBSC_BEAT_WRITE);

  always_comb
  begin
    wr_word = '0;
    rd_word = mem_reg[beat_addr];
    for (int i = 0; i < LANES; i++)
    begin
      wr_word[i*LANE_W +: LANE_W] = {parity_pins_in[i], data_in[i*BYTE_W +: BYTE_W]};
      // the word stored on this very edge is not yet in the array
      if (s2_write && s2_lane_reg[i] && s2_addr_reg == beat_addr)
        rd_word[i*LANE_W +: LANE_W] = wr_word[i*LANE_W +: LANE_W];
    end
  end

  // write data is taken two edges after its address
  always_ff @(posedge core_clk)
  begin
    if (adv && s2_write)
    begin
      for (int i = 0; i < LANES; i++)
        if (s2_lane_reg[i])
          mem_reg[s2_addr_reg][i*LANE_W +: LANE_W] <= wr_word[i*LANE_W +: LANE_W];
    end
  end

  // ==========================================================
  // two entry read buffer
  // ==========================================================
  logic [WORD_W-1:0] buf_reg [2];
  logic [1:0]        buf_cnt_reg;
  logic              buf_head_reg;
  logic              push;
  logic              pop;
  logic [WORD_W-1:0] out_word;

  assign buf_in_ready = (buf_cnt_reg != `SBSC_BUF_DEPTH);
  // read at the load edge so the word leaves one edge later, as write data does
  assign push = adv && (beat == SBSC_BEAT_READ);
  // drained only on a qualified edge, so a stall holds the word
  assign pop  = adv && (s1_beat_reg == SBSC_BEAT_READ) && (buf_cnt_reg != 2'h0);

  // a read right behind a write to the same word takes the new lanes
  always_comb
  begin
    out_word = buf_reg[buf_head_reg];
    for (int i = 0; i < LANES; i++)
      if (s2_write && s2_lane_reg[i] && s2_addr_reg == s1_addr_reg)
        out_word[i*LANE_W +: LANE_W] = wr_word[i*LANE_W +: LANE_W];
  end

  always_ff @(posedge core_clk)
  begin
    if (reset || !awake)
    begin
      buf_cnt_reg  <= `SBSC_BUF_CNT_RST;
      buf_head_reg <= 1'b0;
    end
    else
    begin
      buf_cnt_reg  <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
      buf_head_reg <= buf_head_reg ^ pop;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      buf_reg[buf_head_reg ^ buf_cnt_reg[0]] <= rd_word;
  end

  // ==========================================================
  // output register and drivers
  // ==========================================================
  logic rd_phase_reg;
  logic rd_phase_next;

  assign rd_phase_next = adv ? (s1_beat_reg == SBSC_BEAT_READ) : rd_phase_reg;

  always_ff @(posedge core_clk)
  begin
    if (reset || !awake)
      rd_phase_reg <= 1'b0;
    else
      rd_phase_reg <= rd_phase_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      data_out        <= '0;
      parity_pins_out <= '0;
    end
    else if (pop)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        data_out[i*BYTE_W +: BYTE_W] <= out_word[i*LANE_W +: BYTE_W];
        parity_pins_out[i] <= out_word[i*LANE_W + BYTE_W];
      end
    end
  end

  // enable follows output enable on every edge, stall or not
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      data_oe_n        <= `SBSC_TRI_OFF;
      parity_pins_oe_n <= `SBSC_TRI_OFF;
    end
    else
    begin
      data_oe_n        <= !(rd_phase_next && awake && !oe_n_sync_reg);
      parity_pins_oe_n <= !(rd_phase_next && awake && !oe_n_sync_reg);
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  sequence sq_read_load;
    adv && !burst_step_or_load && selected && write_enable_n;
  endsequence
  sequence sq_write_beat;
    adv && beat == SBSC_BEAT_WRITE;
  endsequence

  a_read_timing: assert property (@(posedge core_clk) disable iff (reset)
    sq_read_load ##1 adv |=> rd_phase_reg)
    else $error("read not presented two edges after address");
  a_write_tristate: assert property (@(posedge core_clk) disable iff (reset)
    sq_write_beat ##1 adv |=> data_oe_n && parity_pins_oe_n)
    else $error("bus driven during write data phase");
  a_stall_holds: assert property (@(posedge core_clk) disable iff (reset)
    clock_qualifier && awake |=> $stable(s1_addr_reg) && $stable(count_reg)
      && $stable(s2_beat_reg))
    else $error("stalled edge changed pipeline");
  a_oe_masks: assert property (@(posedge core_clk) disable iff (reset)
    oe_n_sync_reg |=> data_oe_n)
    else $error("bus driven with output enable off");
  a_reset_tri: assert property (@(posedge core_clk)
    reset |=> data_oe_n && parity_pins_oe_n && !burst_active_reg)
    else $error("bus not tristated after reset");
  a_abort_noop: assert property (@(posedge core_clk) disable iff (reset)
    adv && !burst_step_or_load && selected && !write_enable_n && !any_lane
      |=> s1_beat_reg == SBSC_BEAT_NONE)
    else $error("write abort stored a beat");
  a_burst_step: assert property (@(posedge core_clk) disable iff (reset)
    adv && burst_step_or_load && burst_active_reg |=> count_reg == $past(count_reg) + 2'h1)
    else $error("burst counter did not step");
  a_type_latch: assert property (@(posedge core_clk) disable iff (reset)
    adv && burst_step_or_load |=> $stable(burst_write_reg))
    else $error("burst type changed mid burst");
  a_continue_read: assert property (@(posedge core_clk) disable iff (reset)
    burst_step_or_load && burst_active_reg && !burst_write_reg |-> beat == SBSC_BEAT_READ)
    else $error("read continuation not a read");
  a_sleep_entry: assert property (@(posedge core_clk) disable iff (reset)
    awake && sleep_sync_reg |=> (sleep_state_reg == SBSC_ENTER) [*2]
      ##1 sleep_state_reg == SBSC_ASLEEP)
    else $error("sleep entry not two cycles");
endmodule

// ===== sbsc_master_model.sv
// memory controller model driving the burst sram cycle control block
module sbsc_master_model
(
  input  wire logic        core_clk,
  output logic             chip_select_1_n,
  output logic             chip_select_2,
  output logic             chip_select_3_n,
  output logic             burst_step_or_load,
  output logic             write_enable_n,
  output logic [3:0]       byte_write_select_n,
  output logic             clock_qualifier,
  output logic             burst_order_select,
  output logic             output_enable_n,
  output logic             sleep_request,
  output logic [5:0]       address,
  output logic [31:0]      data_in,
  output logic [3:0]       parity_pins_in,
  output logic             exp_drv,
  output logic [35:0]      exp_word
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // state
  logic [35:0] shadow [64];
  logic [5:0]  base;
  logic [1:0]  n;
  logic        act;
  logic        is_wr;
  logic [1:0]  k1;
  logic [1:0]  k2;
  logic [35:0] e1;
  logic [35:0] e2;
  initial
  begin
    {chip_select_1_n, chip_select_2, chip_select_3_n} = 3'h1;
    {burst_step_or_load, write_enable_n, clock_qualifier} = 3'h2;
    {burst_order_select, output_enable_n, sleep_request} = 3'h0;
    byte_write_select_n = 4'hf;
    address = 6'h00;
    {data_in, parity_pins_in} = 36'h0;
    {k1, k2, act} = 5'h00;
    {e1, e2} = 72'h0;
    exp_drv = 1'b0;
    exp_word = 36'h0;
  end
  // ==========================================================
  // steady pins; deselect before sleep is the caller's duty
  task automatic pins(input logic ord, input logic oe_n, input logic zz);
    burst_order_select = ord;
    output_enable_n = oe_n;
    sleep_request = zz;
  endtask
  task automatic hold(input int k);
    clock_qualifier = 1'b1;
    repeat (k) @(posedge core_clk);
    #1;
    clock_qualifier = 1'b0;
  endtask
  // ==========================================================
  // one qualified beat; sel 0 selects all, 1..3 drops one select
  task automatic beat(input logic step, input logic [1:0] sel, input logic wr,
                      input logic [3:0] ln, input logic [5:0] a, input logic [35:0] w);
    logic [5:0] ea;
    logic [1:0] k;
    burst_step_or_load = step;
    chip_select_1_n = (sel == 2'h1);
    chip_select_2 = (sel != 2'h2);
    chip_select_3_n = (sel == 2'h3);
    write_enable_n = !wr;
    byte_write_select_n = ln;
    address = a;
    @(posedge core_clk);
    #1;
    if (!step)
    begin
      base = a;
      n = 2'h0;
      act = (sel == 2'h0);
      is_wr = wr;
    end
    else
      n = n + 2'h1;
    ea = {base[5:2], (burst_order_select ? (base[1:0] ^ n) : (base[1:0] + n))};
    k = !act ? 2'h0 : (!is_wr ? 2'h1 : ((ln != 4'hf) ? 2'h2 : 2'h0));
    for (int i = 0; i < 4; i++)
      if (k == 2'h2 && !ln[i])
      begin
        shadow[ea][8*i+:8] = w[8*i+:8];
        shadow[ea][32+i] = w[32+i];
      end
    k2 = k1;
    e2 = e1;
    k1 = k;
    e1 = (k == 2'h2) ? w : shadow[ea];
    // idle bus shows inverted data so a stale value never matches
    data_in = (k2 == 2'h2) ? e2[31:0] : ~e2[31:0];
    parity_pins_in = (k2 == 2'h2) ? e2[35:32] : ~e2[35:32];
    exp_drv = (k2 == 2'h1) && !output_enable_n;
    exp_word = e2;
  endtask
endmodule

// ===== tb.sv
// self-checking testbench for the burst sram cycle control block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // signals
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        cs1_n;
  logic        cs2;
  logic        cs3_n;
  logic        step;
  logic        we_n;
  logic [3:0]  lanes_n;
  logic        qual;
  logic        ord;
  logic        oe_n;
  logic        zz;
  logic [5:0]  addr;
  logic [31:0] d_in;
  logic [31:0] data_out;
  logic        data_oe_n;
  logic [3:0]  p_in;
  logic [3:0]  parity_pins_out;
  logic        parity_pins_oe_n;
  logic        exp_drv;
  logic [35:0] exp_word;
  int          n_mismatch = 0;
  int          tests_run = 0;
  always #2 core_clk = ~core_clk;
  sbsc_master_model i_mst (.core_clk(core_clk), .chip_select_1_n(cs1_n),
    .chip_select_2(cs2), .chip_select_3_n(cs3_n), .burst_step_or_load(step),
    .write_enable_n(we_n), .byte_write_select_n(lanes_n), .clock_qualifier(qual),
    .burst_order_select(ord), .output_enable_n(oe_n), .sleep_request(zz),
    .address(addr), .data_in(d_in), .parity_pins_in(p_in), .exp_drv(exp_drv),
    .exp_word(exp_word));
  sbsc_cycle_ctrl #(.ADDR_W(6)) i_dut (.core_clk(core_clk), .reset(reset),
    .chip_select_1_n(cs1_n), .chip_select_2(cs2), .chip_select_3_n(cs3_n),
    .burst_step_or_load(step), .write_enable_n(we_n), .byte_write_select_n(lanes_n),
    .clock_qualifier(qual), .burst_order_select(ord), .output_enable_n(oe_n),
    .sleep_request(zz), .address(addr), .data_in(d_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .parity_pins_in(p_in), .parity_pins_out(parity_pins_out),
    .parity_pins_oe_n(parity_pins_oe_n));
  // ==========================================================
  // helpers
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input logic s, input logic [1:0] sel, input logic wr,
                     input logic [3:0] ln, input logic [5:0] a, input logic [35:0] w);
    i_mst.beat(s, sel, wr, ln, a, w);
    check({35'h0, data_oe_n}, {35'h0, !exp_drv});
    check({35'h0, parity_pins_oe_n}, {35'h0, !exp_drv});
    if (exp_drv)
      check({parity_pins_out, data_out}, exp_word);
  endtask
  task automatic idle(input int k);
    repeat (k) cyc(1'b0, 2'h2, 1'b0, 4'hf, 6'h00, 36'h0);
  endtask
  // ==========================================================
  // scenarios
  task automatic s_fill;
    cyc(1'b0, 2'h0, 1'b1, 4'h0, 6'h0c, 36'ha_aaaa_aaaa);
    repeat (3) cyc(1'b1, 2'h0, 1'b1, 4'h0, 6'h00, 36'h5_5555_5555);
    idle(2);
  endtask
  // partial and empty continuation beats then a read burst right behind
  task automatic s_burst(input logic o, input logic [35:0] d);
    i_mst.pins(o, 1'b0, 1'b0);
    cyc(1'b0, 2'h0, 1'b1, 4'h0, 6'h0d, d);
    cyc(1'b1, 2'h1, 1'b0, 4'h0, 6'h00, ~d);
    cyc(1'b1, 2'h0, 1'b0, 4'ha, 6'h00, d ^ 36'hf_0f0f_0f0f);
    cyc(1'b1, 2'h0, 1'b0, 4'hf, 6'h00, 36'h0);
    cyc(1'b0, 2'h0, 1'b0, 4'h5, 6'h0d, 36'h0);
    repeat (3) cyc(1'b1, 2'h3, 1'b1, 4'h0, 6'h00, 36'h0);
    idle(2);
  endtask
  task automatic s_abort;
    cyc(1'b0, 2'h0, 1'b1, 4'hf, 6'h0d, 36'h0);
    cyc(1'b0, 2'h0, 1'b0, 4'h0, 6'h0d, 36'h0);
    // write right behind a read, then reads right behind the write
    cyc(1'b0, 2'h0, 1'b1, 4'h3, 6'h0d, 36'h6_1234_abcd);
    repeat (2) cyc(1'b0, 2'h0, 1'b0, 4'h0, 6'h0d, 36'h0);
    idle(3);
  endtask
  task automatic s_select;
    for (int s = 1; s < 4; s++)
    begin
      cyc(1'b0, 2'(s), 1'b0, 4'h0, 6'h0d, 36'h0);
      cyc(1'b1, 2'h0, 1'b0, 4'h0, 6'h0d, 36'h0);
      idle(2);
    end
  endtask
  // enable takes a few cycles through its synchroniser, so pad with idles
  task automatic s_dummy;
    i_mst.pins(1'b0, 1'b1, 1'b0);
    idle(3);
    cyc(1'b0, 2'h0, 1'b0, 4'h0, 6'h0e, 36'h0);
    repeat (3) cyc(1'b1, 2'h0, 1'b0, 4'h0, 6'h00, 36'h0);
    idle(3);
    i_mst.pins(1'b0, 1'b0, 1'b0);
    idle(3);
  endtask
  task automatic s_stall;
    cyc(1'b0, 2'h0, 1'b0, 4'h0, 6'h0e, 36'h0);
    i_mst.hold(3);
    check({35'h0, data_oe_n}, {35'h0, !exp_drv});
    cyc(1'b1, 2'h0, 1'b0, 4'h0, 6'h00, 36'h0);
    i_mst.hold(2);
    check({35'h0, data_oe_n}, {35'h0, !exp_drv});
    idle(4);
  endtask
  task automatic s_sleep;
    i_mst.pins(1'b0, 1'b0, 1'b1);
    idle(6);
    i_mst.pins(1'b0, 1'b0, 1'b0);
    idle(6);
    cyc(1'b0, 2'h0, 1'b0, 4'h0, 6'h0f, 36'h0);
    idle(3);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge core_clk);
    #1;
    check({35'h0, data_oe_n}, 36'h1);
    reset = 1'b0;
    idle(4);
    s_fill;
    s_burst(1'b0, 36'h1_2345_6789);
    s_burst(1'b1, 36'h9_8765_4321);
    s_abort;
    s_select;
    s_dummy;
    s_stall;
    s_sleep;
    test_done;
  end
  initial
  begin
    #20000;
    n_mismatch++;
    test_done;
  end
endmodule
